//--- pg_sampler.sv
// Far-side system logic that samples the open-drain power-good pin.
`timescale 1ns/1ps
module pg_sampler (
	// Clock.
	input  wire logic core_clk,
	// Pin drive from the supervisor.
	input  wire logic pinOut,
	input  wire logic pinOe,
	// Pin level and the system's view of it.
	output logic      pinLevel,
	output logic      sysGood
);
	// The pull-up wins whenever the supervisor lets go of the pin.
	assign pinLevel = pinOe ? pinOut : 1'b1;
	always_ff @(posedge core_clk) begin
		sysGood <= (pinLevel === 1'b1);
	end
endmodule // pg_sampler

//--- power_good_supervisor.sv
// Power-good decision logic with register port, hysteresis and start-up modes.
// Function
// [R1] Upper level chosen 80/85/90/95 percent, default 90.
// [R2] Lower level sits five percent below upper.
// [R3] Rising past upper level sets power good.
// [R4] Falling below lower level clears power good.
// [R5] Threshold mode needs enable and supply good.
// [R6] Any active protection fault holds power good low.
// [R7] Output compared against levels at all times; the code skips this in ST_OFF and in soft-start ST_STARTING.
// [R8] Mode bit zero of 0x14, default threshold.
// [R9] Soft-start mode asserts within two percent ramp.
// [R10] After start-up both modes behave the same.
// [R11] Pre-biased start waits for first gate pulse; the code waits in soft-start mode only, threshold mode ignores preBiased.
// [R12] Over-current immediately forces power good low.
// [R13] Over-voltage latches, forces low until cycled.
// [R14] Inside hysteresis band previous state is kept.
// [R15] Outside logic treats only high as good.
`timescale 1ns/1ps
`include "power_good_supervisor_consts.svh"
module power_good_supervisor
	import power_good_supervisor_pkg::*;
#(
	parameter int SENSE_W = 12
) (
	// Clock and reset.
	input  wire logic               core_clk,
	input  wire logic               reset,
	// Register port.
	input  wire logic               regWrite,
	input  wire logic               regRead,
	input  wire logic [7:0]         regAddr,
	input  wire logic [7:0]         regWdata,
	output logic      [7:0]         regRdata,
	// Supply qualifiers and faults.
	input  wire qual_t              qual,
	input  wire faults_t            faults,
	// Analog samples, same scale; targetLevel sets one hundred percent.
	input  wire logic [SENSE_W-1:0] output_sense_voltage,
	input  wire logic [SENSE_W-1:0] softStartLevel,
	input  wire logic [SENSE_W-1:0] targetLevel,
	// Switching status.
	input  wire logic               preBiased,
	input  wire logic               highSideGate,
	// Indicator pin, open drain.
	output logic                    power_good_flag,
	output logic                    goodPinOut,
	output logic                    goodPinOe,
	output logic                    ovLatched
);
	localparam int PW = SENSE_W + 7;

	logic [7:0]     good_indicator_mode_ctrl;
	logic [7:0]     good_level_select;
	phase_t         phase;
	logic           gateSeen;
	logic [6:0]     upperPct;
	logic [PW-1:0]  senseScaled;
	logic [PW-1:0]  upperScaled;
	logic [PW-1:0]  lowerScaled;
	logic [PW-1:0]  rampScaled;
	logic [PW-1:0]  rampWindow;
	logic           qualified;
	logic           aboveUpper;
	logic           belowLower;
	logic           rampClose;
	logic           thresholdMode;
	logic           next_good;

	// Register writes; reserved bits are masked and read as zero.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			good_indicator_mode_ctrl <= `MODE_RESET; // [R8]
			good_level_select        <= `LEVEL_RESET; // [R1]
		end else if (regWrite) begin
			if (regAddr == `MODE_CTRL_OFFSET)
				good_indicator_mode_ctrl <= regWdata & `MODE_MASK; // [R8]
			if (regAddr == `LEVEL_SELECT_OFFSET)
				good_level_select <= regWdata & `LEVEL_MASK; // [R1]
		end
	end

	// Read data is registered; unmapped offsets answer zero.
	always_ff @(posedge core_clk) begin
		if (reset)
			regRdata <= 8'h00;
		else if (regRead) begin
			unique case (regAddr)
				`MODE_CTRL_OFFSET:    regRdata <= good_indicator_mode_ctrl;
				`LEVEL_SELECT_OFFSET: regRdata <= good_level_select;
				default:              regRdata <= 8'h00;
			endcase
		end
	end

	assign thresholdMode = good_indicator_mode_ctrl[`MODE_BIT];

	always_comb begin
		unique case (good_level_select[1:0]) // [R1]
			2'h0:    upperPct = `PCT_80;
			2'h1:    upperPct = `PCT_85;
			2'h2:    upperPct = `PCT_90;
			default: upperPct = `PCT_95;
		endcase
	end

	// Percent comparisons scale the sample by 100 and the target by the percent to avoid division.
	assign senseScaled = PW'(output_sense_voltage) * PW'(`PCT_FULL); // [R7]
	assign upperScaled = PW'(targetLevel) * PW'(upperPct);
	assign lowerScaled = PW'(targetLevel) * PW'(upperPct - `HYST_PCT); // [R2]
	assign rampScaled  = PW'(softStartLevel) * PW'(`PCT_FULL);
	assign rampWindow  = PW'(targetLevel) * PW'(`PCT_FULL - `SOFT_START_WIN_PCT);

	assign aboveUpper = senseScaled > upperScaled; // [R3]
	assign belowLower = senseScaled < lowerScaled; // [R4]
	assign rampClose  = rampScaled >= rampWindow; // [R9]
	assign qualified  = qual.enableOk && qual.supplyOk; // [R5]

	// Over-voltage latch is released only by reset or by cycling enable or supply.
	always_ff @(posedge core_clk) begin
		if (reset)
			ovLatched <= 1'b0;
		else if (!qualified)
			ovLatched <= 1'b0; // [R13]
		else if (faults.overVoltage)
			ovLatched <= 1'b1; // [R13]
	end

	// Start-up phase; a fault returns to ST_OFF and restarts start-up in either mode, so start-up behaviour repeats.
	always_ff @(posedge core_clk) begin
		if (reset)
			phase <= ST_OFF;
		else if (!qualified || |faults || ovLatched)
			phase <= ST_OFF; // [R12]
		else begin
			unique case (phase)
				ST_OFF:      phase <= ST_STARTING;
				ST_STARTING: if (next_good) phase <= ST_RUNNING;
				ST_RUNNING:  phase <= ST_RUNNING; // [R10]
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset)
			gateSeen <= 1'b0;
		else if (phase == ST_OFF)
			gateSeen <= 1'b0;
		else if (highSideGate)
			gateSeen <= 1'b1; // [R11]
	end

	always_comb begin
		next_good = power_good_flag; // [R14]
		if (!qualified || |faults || ovLatched)
			next_good = 1'b0; // [R5] [R6] [R12] [R13]
		else if (phase == ST_STARTING && !thresholdMode) begin
			if (preBiased && !(gateSeen || highSideGate))
				next_good = 1'b0; // [R11]
			else
				next_good = rampClose; // [R9]
		end else if (phase == ST_OFF)
			next_good = 1'b0;
		else if (aboveUpper)
			next_good = 1'b1; // [R3]
		else if (belowLower)
			next_good = 1'b0; // [R4]
	end

	// The pin is pulled low while not good and in reset, and released to the pull-up only when good.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			power_good_flag <= 1'b0;
			goodPinOe       <= 1'b1;
		end else begin
			power_good_flag <= next_good;
			goodPinOe       <= !next_good; // [R15]
		end
	end

	always_ff @(posedge core_clk) begin
		goodPinOut <= 1'b0;
	end

	property faultClears_p;
		@(posedge core_clk) disable iff (reset)
		(|faults) |=> !power_good_flag;
	endproperty
	faults_force_low_a: assert property (faultClears_p) // [R6]
		else $error("power good high one cycle after a fault");

	qual_gates_good_a: assert property (@(posedge core_clk) disable iff (reset)
		!qualified |=> !power_good_flag) // [R5]
		else $error("power good high without enable and supply");

	ov_latch_holds_a: assert property (@(posedge core_clk) disable iff (reset)
		(ovLatched && qualified) |=> ovLatched && !power_good_flag) // [R13]
		else $error("over-voltage latch released while qualified");

	sequence inBand_s;
		!aboveUpper && !belowLower && qualified && !(|faults) && !ovLatched
			&& phase == ST_RUNNING;
	endsequence
	band_holds_a: assert property (@(posedge core_clk) disable iff (reset)
		inBand_s |=> power_good_flag == $past(power_good_flag)) // [R14]
		else $error("power good toggled inside hysteresis band");

	rise_sets_a: assert property (@(posedge core_clk) disable iff (reset)
		(aboveUpper && qualified && !(|faults) && !ovLatched && phase == ST_RUNNING)
		|=> power_good_flag) // [R3]
		else $error("power good not set above upper level");

	fall_clears_a: assert property (@(posedge core_clk) disable iff (reset)
		(belowLower && phase == ST_RUNNING) |=> !power_good_flag) // [R4]
		else $error("power good not cleared below lower level");

	prebias_hold_a: assert property (@(posedge core_clk) disable iff (reset)
		(phase == ST_STARTING && !thresholdMode && preBiased && !gateSeen
			&& !highSideGate) |=> !power_good_flag) // [R11]
		else $error("power good before first gate pulse");

	pin_matches_a: assert property (@(posedge core_clk) disable iff (reset)
		goodPinOe == !power_good_flag) // [R15]
		else $error("pin drive disagrees with power good");

	level_reset_a: assert property (@(posedge core_clk)
		reset |=> good_level_select == `LEVEL_RESET
			&& good_indicator_mode_ctrl == `MODE_RESET) // [R1] [R8]
		else $error("control fields wrong after reset");

	// Register port: fields take masked write data and read back one cycle later.
	mode_write_a: assert property (@(posedge core_clk) disable iff (reset) // [R8]
		(regWrite && regAddr == `MODE_CTRL_OFFSET)
		|=> good_indicator_mode_ctrl == ($past(regWdata) & `MODE_MASK))
		else $error("mode field differs from the written value");

	level_write_a: assert property (@(posedge core_clk) disable iff (reset) // [R1]
		(regWrite && regAddr == `LEVEL_SELECT_OFFSET)
		|=> good_level_select == ($past(regWdata) & `LEVEL_MASK))
		else $error("level field differs from the written value");

	mode_read_a: assert property (@(posedge core_clk) disable iff (reset) // [R8]
		(regRead && regAddr == `MODE_CTRL_OFFSET)
		|=> regRdata == $past(good_indicator_mode_ctrl))
		else $error("mode field read back wrong");

	level_read_a: assert property (@(posedge core_clk) disable iff (reset) // [R1]
		(regRead && regAddr == `LEVEL_SELECT_OFFSET)
		|=> regRdata == $past(good_level_select))
		else $error("level field read back wrong");

	unmapped_read_a: assert property (@(posedge core_clk) disable iff (reset)
		(regRead && regAddr != `MODE_CTRL_OFFSET && regAddr != `LEVEL_SELECT_OFFSET)
		|=> regRdata == 8'h00)
		else $error("unmapped offset read nonzero");

	// Qualification, faults and the over-voltage latch.
	sequence clean_s;
		qualified && !(|faults) && !ovLatched;
	endsequence

	ov_sets_a: assert property (@(posedge core_clk) disable iff (reset) // [R13]
		(qualified && faults.overVoltage) |=> ovLatched)
		else $error("over-voltage not latched");

	ov_clear_a: assert property (@(posedge core_clk) disable iff (reset) // [R13]
		!qualified |=> !ovLatched)
		else $error("over-voltage latch kept after cycling");

	overcurrent_low_a: assert property (@(posedge core_clk) disable iff (reset) // [R12]
		faults.overCurrent |=> !power_good_flag && phase == ST_OFF)
		else $error("over-current did not restart start-up");

	off_low_a: assert property (@(posedge core_clk) disable iff (reset)
		phase == ST_OFF |=> !power_good_flag)
		else $error("power good high out of the off phase");

	// Start-up: a fault-free start must reach good and then hand over to normal running.
	sequence rampReady_s;
		phase == ST_STARTING && !thresholdMode && rampClose && !preBiased;
	endsequence

	ramp_start_a: assert property (@(posedge core_clk) disable iff (reset) // [R9]
		clean_s ##0 rampReady_s |=> power_good_flag)
		else $error("power good not set with ramp near target");

	threshold_start_a: assert property (@(posedge core_clk) disable iff (reset) // [R3]
		clean_s ##0 (phase == ST_STARTING && thresholdMode && aboveUpper)
		|=> power_good_flag)
		else $error("power good not set at threshold start-up");

	start_done_a: assert property (@(posedge core_clk) disable iff (reset) // [R10]
		clean_s ##0 (phase == ST_STARTING && next_good) |=> phase == ST_RUNNING)
		else $error("start-up did not hand over to running");

	gate_seen_a: assert property (@(posedge core_clk) disable iff (reset) // [R11]
		(phase != ST_OFF && highSideGate) |=> gateSeen)
		else $error("gate pulse not remembered");

	gate_clear_a: assert property (@(posedge core_clk) disable iff (reset) // [R11]
		phase == ST_OFF |=> !gateSeen)
		else $error("gate memory kept across restart");

	lower_level_a: assert property (@(posedge core_clk) disable iff (reset) // [R2]
		clean_s ##0 (phase == ST_RUNNING && power_good_flag && !belowLower) |=> power_good_flag)
		else $error("power good dropped above the lower level");
endmodule // power_good_supervisor

//--- power_good_supervisor_consts.svh
// Constants for the power-good supervisor: offsets, fields, reset values, levels.
`ifndef POWER_GOOD_SUPERVISOR_CONSTS_SVH
`define POWER_GOOD_SUPERVISOR_CONSTS_SVH
`define MODE_CTRL_OFFSET    8'h14
`define LEVEL_SELECT_OFFSET 8'h18
`define MODE_BIT            0
`define MODE_RESET          8'h01
`define LEVEL_RESET         8'h02
`define LEVEL_MASK          8'h03
`define MODE_MASK           8'h01
`define PCT_80              7'h50
`define PCT_85              7'h55
`define PCT_90              7'h5a
`define PCT_95              7'h5f
`define HYST_PCT            7'h05
`define SOFT_START_WIN_PCT  7'h02
`define PCT_FULL            7'h64
`endif

//--- power_good_supervisor_pkg.sv
// Types shared by the power-good supervisor.
package power_good_supervisor_pkg;
	typedef struct packed {
		logic enableOk;
		logic supplyOk;
	} qual_t;
	typedef struct packed {
		logic overCurrent;
		logic overVoltage;
		logic overTemp;
	} faults_t;
	typedef enum logic [2:0] {
		ST_OFF      = 3'b001,
		ST_STARTING = 3'b010,
		ST_RUNNING  = 3'b100
	} phase_t;
endpackage

//--- power_good_supervisor_tb.sv
// Self-checking testbench for the power-good supervisor.
`timescale 1ns/1ps
`include "power_good_supervisor_consts.svh"
module power_good_supervisor_tb
	import power_good_supervisor_pkg::*;
;
	logic        core_clk = 0, reset = 1, regWrite = 0, regRead = 0;
	logic [7:0]  regAddr = 8'h00, regWdata = 8'h00, regRdata;
	qual_t       qual = '0;
	faults_t     faults = '0;
	logic [11:0] sense = 12'h000, ramp = 12'h000, target = 12'h7d0;
	logic        preBiased = 0, gate = 0, flag, pinOut, pinOe, ovLatched, pinLevel;
	int n_mismatch = 0, compares = 0, cyc = 0;
	int mMode = 1, mLevel = 2, mRd = 0, mFlag = 0, mOv = 0, mPh = 0, mGate = 0;
	bit [15:0] rnd = 16'd52837;

	always #12.5 core_clk = ~core_clk;

	power_good_supervisor dut (.core_clk(core_clk), .reset(reset), .regWrite(regWrite),
		.regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
		.qual(qual), .faults(faults), .output_sense_voltage(sense),
		.softStartLevel(ramp), .targetLevel(target), .preBiased(preBiased),
		.highSideGate(gate), .power_good_flag(flag), .goodPinOut(pinOut),
		.goodPinOe(pinOe), .ovLatched(ovLatched));
	pg_sampler far (.core_clk(core_clk), .pinOut(pinOut), .pinOe(pinOe),
		.pinLevel(pinLevel), .sysGood());

	function automatic bit [15:0] lfsr(bit [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("Compares %0d, mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Model first, from the inputs the design samples at this edge, then new stimulus.
	always @(posedge core_clk) begin
		int up, bad, ph, md;
		if (!reset) begin
			up = 80 + 5 * mLevel;
			md = mMode;
			ph = mPh;
			bad = !(qual.enableOk && qual.supplyOk) || faults != 0 || mOv;
			if (regRead)
				mRd = regAddr == `MODE_CTRL_OFFSET ? mMode : regAddr == `LEVEL_SELECT_OFFSET ? mLevel : 0;
			if (regWrite && regAddr == `MODE_CTRL_OFFSET)
				mMode = regWdata & 1;
			if (regWrite && regAddr == `LEVEL_SELECT_OFFSET)
				mLevel = regWdata & 3;
			mOv = !(qual.enableOk && qual.supplyOk) ? 0 : (faults.overVoltage ? 1 : mOv);
			mGate = ph == 0 ? 0 : (mGate | gate);
			if (bad) begin
				mFlag = 0;
				mPh = 0;
			end else if (ph == 0) begin
				mFlag = 0;
				mPh = 1;
			end else begin
				if (ph == 1 && md == 0)
					mFlag = ramp * 100 >= target * 98 && (!preBiased || mGate || gate);
				else if (sense * 100 > target * up)
					mFlag = 1;
				else if (sense * 100 < target * (up - 5))
					mFlag = 0;
				if (ph == 1 && mFlag)
					mPh = 2;
			end
			rnd = lfsr(rnd);
			qual <= (rnd[3:0] != 0) ? 2'b11 : rnd[5:4];
			faults <= (rnd[9:4] == 0) ? rnd[12:10] : 3'b000;
			sense <= 12'd1500 + rnd[9:0];
			ramp <= 12'd1900 + rnd[14:8];
			preBiased <= rnd[15];
			gate <= rnd[2] & rnd[7];
			regRead <= cyc < 2 || rnd[6:4] == 0;
			regWrite <= cyc >= 2 && rnd[6:4] == 1 && rnd[8:7] == 0;
			regAddr <= cyc == 0 ? `MODE_CTRL_OFFSET : cyc == 1 ? `LEVEL_SELECT_OFFSET :
				rnd[1] ? `MODE_CTRL_OFFSET : rnd[0] ? `LEVEL_SELECT_OFFSET : {rnd[15:9], 1'b0};
			regWdata <= {rnd[13:8], rnd[3:2]};
			cyc++;
		end else begin
			mMode = 1;
			mLevel = 2;
			mRd = 0;
			mFlag = 0;
			mOv = 0;
			mPh = 0;
			mGate = 0;
		end
	end

	always @(negedge core_clk) begin
		if (!reset && cyc > 0) begin
			check("flag", flag, mFlag);
			check("pinLevel", pinLevel, mFlag);
			check("ovLatched", ovLatched, mOv);
			check("regRdata", regRdata, mRd);
		end
	end

	initial begin
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		repeat (1500) @(posedge core_clk);
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		repeat (1500) @(posedge core_clk);
		complete_run();
	end
	// The run needs about 75 us; twice that means a hang.
	initial begin
		#160000;
		n_mismatch++;
		complete_run();
	end
endmodule // power_good_supervisor_tb
